// *** aea_params.svh ***
// Purpose: constants for the apparent energy accumulator
// Assumes: 20 MHz reference clock acting as the master clock
// Notes: offsets are register indexes on the plain register port
`ifndef AEA_PARAMS_SVH
`define AEA_PARAMS_SVH

// ----------------------------------------
// bus and datapath widths
// ----------------------------------------
`define AEA_ADDR_W 8
`define AEA_DATA_W 16
`define AEA_RMS_W 16
`define AEA_WORD_W 24
`define AEA_ACC_W 41
`define AEA_REG_LSB 25
`define AEA_GAIN_W 12
`define AEA_GAIN_FRAC 12
`define AEA_GAIN_UNITY 13'h1000
// apparent weight trim, about 1.0005 of unity
`define AEA_VA_WEIGHT 12'h002
`define AEA_CLK_PERIOD_NS 50
`define AEA_SAMPLE_CLKS 4
`define AEA_SAMPLE_LAST 2'h3
`define AEA_DFC_THRESH 26'h0100000

// ----------------------------------------
// register indexes
// ----------------------------------------
`define AEA_OFF_ENERGY_A 8'h00
`define AEA_OFF_ENERGY_B 8'h01
`define AEA_OFF_ENERGY_C 8'h02
`define AEA_OFF_COMPUTATION_MODE_REG 8'h03
`define AEA_OFF_WAVEMODE 8'h04
`define AEA_OFF_LINE_CYCLE_MODE_REG 8'h05
`define AEA_OFF_DIVIDER 8'h06
`define AEA_OFF_VAGAIN0 8'h07
`define AEA_OFF_IGAIN0 8'h0A
`define AEA_OFF_VRMSGAIN0 8'h0D
`define AEA_OFF_PULSE_NUM 8'h10
`define AEA_OFF_PULSE_DEN 8'h11
`define AEA_OFF_ZC_COUNT 8'h12
`define AEA_OFF_STATUS 8'h13

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define AEA_BIT_APPARENT_PULSE 7
`define AEA_BIT_LC_ACTIVE 0
`define AEA_BIT_LC_REACTIVE 1
`define AEA_BIT_LC_APPARENT 2
`define AEA_BIT_READ_CLEAR 6
`define AEA_RST_COMPUTATION_MODE_REG 5'h1C
`define AEA_RST_ZC_COUNT 16'hFFFF
`define AEA_RST_PULSE_DEN 12'h03F

`endif

// *** aea_pkg.sv ***
// Purpose: shared types of the apparent energy accumulator
// Assumes: nothing beyond the constants header
// Notes: enum codes are one-hot where they are states
package aea_pkg;

   typedef enum logic [1:0] {
      AEA_LC_IDLE = 2'h1,
      AEA_LC_RUN = 2'h2
   } aea_lc_state_t;

   typedef enum logic [1:0] {
      AEA_SEL_OWN = 2'h0,
      AEA_SEL_AVG_B = 2'h1,
      AEA_SEL_OWN_ALT = 2'h2,
      AEA_SEL_RSVD = 2'h3
   } aea_phase_input_select_t;

endpackage : aea_pkg

// *** aea_phase_acc.sv ***
// Purpose: one phase of gain-scaled, divided apparent energy accumulation
// Assumes: rms inputs come from logic on the same clock
// Notes: accumulator wraps at 41 bits
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_phase_acc
   import aea_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // control
   input wire logic sample_tick_i,
   input wire logic clear_i,
   input wire logic [`AEA_RMS_W-1:0] vrms_i,
   input wire logic [`AEA_RMS_W-1:0] irms_i,
   input wire logic [`AEA_GAIN_W-1:0] current_gain_i,
   input wire logic [`AEA_GAIN_W-1:0] voltage_rms_gain_i,
   input wire logic [`AEA_GAIN_W-1:0] apparent_power_gain_i,
   input wire logic [7:0] divider_i,
   // results
   output logic [`AEA_WORD_W-1:0] word_o,
   output logic [`AEA_ACC_W-1:0] acc_o
);

   function automatic logic [`AEA_WORD_W-1:0] gscale(input logic [`AEA_WORD_W-1:0] v,
                                                     input logic [`AEA_GAIN_W-1:0] g);
      logic [12:0] f;
      logic [36:0] p;
      f = `AEA_GAIN_UNITY + {g[`AEA_GAIN_W-1], g};
      p = {13'h0, v} * {24'h0, f};
      return p[`AEA_GAIN_FRAC+`AEA_WORD_W-1:`AEA_GAIN_FRAC];
   endfunction : gscale

   logic [31:0] raw_prod;
   logic [`AEA_WORD_W-1:0] raw_word;
   logic [`AEA_WORD_W-1:0] scaled;
   logic [7:0] div_eff;
   logic [`AEA_WORD_W-1:0] divided;
   logic [`AEA_WORD_W-1:0] word_q;
   logic [`AEA_ACC_W-1:0] acc_q;

   assign raw_prod = vrms_i * irms_i;
   assign raw_word = {4'h0, raw_prod[31:12]}; // R04
   // gains and weight trim applied in series
   assign scaled = gscale(gscale(gscale(gscale(raw_word, current_gain_i), voltage_rms_gain_i),
                                 apparent_power_gain_i), `AEA_VA_WEIGHT); // R07 R16
   assign div_eff = (divider_i < 8'h02) ? 8'h01 : divider_i; // R17 R05
   assign divided = scaled / {16'h0, div_eff}; // R17

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         word_q <= '0;
      end else begin
         word_q <= divided;
      end
   end

   // a sample landing on a clear starts the new total
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         acc_q <= '0;
      end else if (sample_tick_i) begin
         acc_q <= (clear_i ? '0 : acc_q) + {17'h0, word_q}; // R01 R02 R19
      end else if (clear_i) begin
         acc_q <= '0;
      end
   end

   assign word_o = word_q;
   assign acc_o = acc_q;

   property p_acc_add;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (sample_tick_i && !clear_i) |=> (acc_q == $past(acc_q) + {17'h0, $past(word_q)});
   endproperty
   a_acc_add: assert property (p_acc_add) else $error("accumulator missed a sample"); // R02

   property p_no_div;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (divider_i < 8'h02) |=> (word_q == $past(scaled));
   endproperty
   a_no_div: assert property (p_no_div) else $error("divider 0 or 1 changed the word"); // R17

endmodule : aea_phase_acc

// *** aea_pulse_dfc.sv ***
// Purpose: digital-to-frequency converter with numerator/denominator divider
// Assumes: one input word per sample tick
// Notes: zero numerator or denominator acts as one
`timescale 1ns/10ps
`include "aea_params.svh"
module aea_pulse_dfc
   import aea_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // power input
   input wire logic sample_tick_i,
   input wire logic apparent_sel_i,
   input wire logic [25:0] apparent_total_i,
   input wire logic [25:0] reactive_total_i,
   input wire logic [11:0] numerator_i,
   input wire logic [11:0] denominator_i,
   // pulse out
   output logic pulse_o
);

   logic [25:0] dfc_in;
   logic [26:0] dfc_sum;
   logic dfc_fire;
   logic [11:0] num_eff;
   logic [11:0] den_eff;
   logic [12:0] div_sum;
   logic div_fire;
   logic [25:0] dfc_acc_q;
   logic [12:0] div_acc_q;
   logic pulse_q;

   // only one power source reaches the converter
   assign dfc_in = apparent_sel_i ? apparent_total_i : reactive_total_i; // R09 R12
   assign dfc_sum = {1'b0, dfc_acc_q} + {1'b0, dfc_in};
   assign dfc_fire = sample_tick_i && (dfc_sum >= {1'b0, `AEA_DFC_THRESH});
   assign num_eff = (numerator_i == 12'h000) ? 12'h001 : numerator_i;
   assign den_eff = (denominator_i == 12'h000) ? 12'h001 : denominator_i;
   assign div_sum = div_acc_q + {1'b0, num_eff};
   assign div_fire = dfc_fire && (div_sum >= {1'b0, den_eff});

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         dfc_acc_q <= '0;
         div_acc_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         if (sample_tick_i) begin
            dfc_acc_q <= dfc_fire ? 26'(dfc_sum - {1'b0, `AEA_DFC_THRESH}) : dfc_sum[25:0];
         end
         if (dfc_fire) begin
            div_acc_q <= div_fire ? div_sum - {1'b0, den_eff} : div_sum; // R11
         end
         pulse_q <= div_fire;
      end
   end

   assign pulse_o = pulse_q;

   property p_source_sel;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      apparent_sel_i |-> (dfc_in == apparent_total_i);
   endproperty
   a_source_sel: assert property (p_source_sel) else $error("apparent source not selected"); // R09

endmodule : aea_pulse_dfc

// *** aea_top.sv ***
// Purpose: three-phase apparent energy accumulation with registers and pulse
// Assumes: rms, zero-crossing and reactive inputs come from same-clock logic
// Notes: reads return data in the cycle after the read strobe
`timescale 1ns/10ps
`include "aea_params.svh"
// Functional notes
// [R01] add each phase every four clocks
// [R02] 41-bit unsigned internal accumulator per phase
// [R03] readable energy register is 16 bits
// [R04] full-scale power word averages given constant
// [R05] divider lengthens overflow time proportionally
// [R06] select field picks per-phase accumulator inputs
// [R07] current, voltage and apparent gains scale energy
// [R08] host avoids current gain in mode zero
// [R09] select bit routes apparent power to pulse
// [R10] three include bits build pulse total
// [R11] numerator and denominator scale pulse rate
// [R12] pulse carries reactive or apparent, not both
// [R13] line-cycle mode latches totals per period
// [R14] host keeps read-clear off in line-cycle
// [R15] active and reactive share zero-crossing period
// [R16] apparent weight trimmed near active weight
// [R17] divide by 8-bit divider, 0/1 none
// [R18] register shows upper 16 accumulator bits
// [R19] overflow wraps to zero and continues
// [R20] read-with-clear zeroes register after read
// [R21] each line-cycle period restarts from zero
module aea_top
   import aea_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [`AEA_ADDR_W-1:0] addr_i,
   input wire logic [`AEA_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`AEA_DATA_W-1:0] rd_data_o,
   // measurement inputs
   input wire logic [`AEA_RMS_W-1:0] vrms_a_i,
   input wire logic [`AEA_RMS_W-1:0] vrms_b_i,
   input wire logic [`AEA_RMS_W-1:0] vrms_c_i,
   input wire logic [`AEA_RMS_W-1:0] irms_a_i,
   input wire logic [`AEA_RMS_W-1:0] irms_b_i,
   input wire logic [`AEA_RMS_W-1:0] irms_c_i,
   input wire logic zero_cross_i,
   input wire logic [25:0] reactive_total_i,
   // outputs
   output logic reactive_pulse_out_o,
   output logic line_cycle_active_o,
   output logic line_cycle_reactive_o,
   output logic period_end_o
);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic [4:0] computation_mode_reg_q;
   logic [7:0] wavemode_q;
   logic [6:0] line_cycle_mode_reg_q;
   logic [7:0] divider_q;
   logic [11:0] pulse_num_q;
   logic [11:0] pulse_den_q;
   logic [15:0] zc_count_q;
   logic [11:0] apparent_power_gain_q [3];
   logic [11:0] current_gain_q [3];
   logic [11:0] voltage_rms_gain_q [3];

   wire wr_comp = wr_i && (addr_i == `AEA_OFF_COMPUTATION_MODE_REG);
   wire wr_wave = wr_i && (addr_i == `AEA_OFF_WAVEMODE);
   wire wr_lcyc = wr_i && (addr_i == `AEA_OFF_LINE_CYCLE_MODE_REG);
   wire wr_div = wr_i && (addr_i == `AEA_OFF_DIVIDER);
   wire wr_num = wr_i && (addr_i == `AEA_OFF_PULSE_NUM);
   wire wr_den = wr_i && (addr_i == `AEA_OFF_PULSE_DEN);
   wire wr_zc = wr_i && (addr_i == `AEA_OFF_ZC_COUNT);

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         computation_mode_reg_q <= `AEA_RST_COMPUTATION_MODE_REG;
         wavemode_q <= '0;
         line_cycle_mode_reg_q <= '0;
         divider_q <= '0;
         pulse_num_q <= '0;
         pulse_den_q <= `AEA_RST_PULSE_DEN;
         zc_count_q <= `AEA_RST_ZC_COUNT;
      end else begin
         if (wr_comp) computation_mode_reg_q <= wr_data_i[4:0];
         if (wr_wave) wavemode_q <= wr_data_i[7:0];
         if (wr_lcyc) line_cycle_mode_reg_q <= wr_data_i[6:0];
         if (wr_div) divider_q <= wr_data_i[7:0];
         if (wr_num) pulse_num_q <= wr_data_i[11:0];
         if (wr_den) pulse_den_q <= wr_data_i[11:0];
         if (wr_zc) zc_count_q <= wr_data_i;
      end
   end

   wire [1:0] phase_input_select = computation_mode_reg_q[1:0];
   wire [2:0] total_phase_include = computation_mode_reg_q[4:2];
   wire apparent_pulse_select = wavemode_q[`AEA_BIT_APPARENT_PULSE];
   wire line_cycle_apparent_en = line_cycle_mode_reg_q[`AEA_BIT_LC_APPARENT];
   wire read_with_clear = line_cycle_mode_reg_q[`AEA_BIT_READ_CLEAR];

   // ----------------------------------------
   // sample tick, one in four clocks
   // ----------------------------------------
   logic [1:0] tick_cnt_q;
   wire sample_tick = (tick_cnt_q == `AEA_SAMPLE_LAST);

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 2'h1; // R01
      end
   end

   // ----------------------------------------
   // line-cycle period control
   // ----------------------------------------
   aea_lc_state_t lc_state_q;
   logic [15:0] zc_seen_q;
   logic period_end_q;
   logic lc_active_q;
   logic lc_reactive_q;
   wire [15:0] zc_target = (zc_count_q == 16'h0000) ? 16'h0001 : zc_count_q;
   wire lc_start = (lc_state_q == AEA_LC_IDLE) && line_cycle_apparent_en;
   wire lc_done = (lc_state_q == AEA_LC_RUN) && zero_cross_i && ((zc_seen_q + 16'h0001) >= zc_target);

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         lc_state_q <= AEA_LC_IDLE;
         zc_seen_q <= '0;
      end else begin
         unique case (lc_state_q)
            AEA_LC_IDLE: begin
               zc_seen_q <= '0;
               if (line_cycle_apparent_en) lc_state_q <= AEA_LC_RUN; // R13
            end
            AEA_LC_RUN: begin
               if (!line_cycle_apparent_en) begin
                  lc_state_q <= AEA_LC_IDLE;
               end else if (lc_done) begin
                  zc_seen_q <= '0;
               end else if (zero_cross_i) begin
                  zc_seen_q <= zc_seen_q + 16'h0001;
               end
            end
            default: lc_state_q <= AEA_LC_IDLE;
         endcase
      end
   end

   // shared period marker lets active and reactive paths align
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         period_end_q <= 1'b0;
         lc_active_q <= 1'b0;
         lc_reactive_q <= 1'b0;
      end else begin
         period_end_q <= lc_done;
         lc_active_q <= line_cycle_mode_reg_q[`AEA_BIT_LC_ACTIVE]; // R15
         lc_reactive_q <= line_cycle_mode_reg_q[`AEA_BIT_LC_REACTIVE]; // R15
      end
   end

   // ----------------------------------------
   // per-phase accumulation
   // ----------------------------------------
   wire [`AEA_RMS_W-1:0] vrms_in [3];
   wire [`AEA_RMS_W-1:0] irms_in [3];
   wire [16:0] v_sum_ac = {1'b0, vrms_a_i} + {1'b0, vrms_c_i};
   wire [`AEA_RMS_W-1:0] v_avg_ac = v_sum_ac[16:1];
   wire [`AEA_WORD_W-1:0] word [3];
   wire [`AEA_ACC_W-1:0] acc [3];
   wire [15:0] live_reg [3];
   logic [15:0] snap_q [3];
   wire [2:0] rd_energy;
   wire [2:0] clr;

   // reserved code 11 falls back to own-phase inputs
   assign vrms_in[0] = vrms_a_i;
   assign vrms_in[1] = (phase_input_select == AEA_SEL_AVG_B) ? v_avg_ac : vrms_b_i; // R06
   assign vrms_in[2] = vrms_c_i;
   assign irms_in[0] = irms_a_i;
   assign irms_in[1] = irms_b_i;
   assign irms_in[2] = irms_c_i;

   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_phase
         wire wr_vag = wr_i && (addr_i == (`AEA_OFF_VAGAIN0 + 8'(gp)));
         wire wr_ig = wr_i && (addr_i == (`AEA_OFF_IGAIN0 + 8'(gp)));
         wire wr_vg = wr_i && (addr_i == (`AEA_OFF_VRMSGAIN0 + 8'(gp)));

         always_ff @(posedge ref_clk_i) begin
            if (!nrst_i) begin
               apparent_power_gain_q[gp] <= '0;
               current_gain_q[gp] <= '0;
               voltage_rms_gain_q[gp] <= '0;
               snap_q[gp] <= '0;
            end else begin
               if (wr_vag) apparent_power_gain_q[gp] <= wr_data_i[11:0];
               if (wr_ig) current_gain_q[gp] <= wr_data_i[11:0];
               if (wr_vg) voltage_rms_gain_q[gp] <= wr_data_i[11:0];
               if (lc_done) snap_q[gp] <= acc[gp][`AEA_ACC_W-1:`AEA_REG_LSB]; // R13
            end
         end

         assign live_reg[gp] = acc[gp][`AEA_ACC_W-1:`AEA_REG_LSB]; // R18 R03
         assign rd_energy[gp] = rd_i && (addr_i == (`AEA_OFF_ENERGY_A + 8'(gp)));
         // read clear acts at the read edge, so the old value is returned
         assign clr[gp] = lc_start || lc_done ||
                          (rd_energy[gp] && read_with_clear && !line_cycle_apparent_en); // R20 R21

         aea_phase_acc u_acc (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .sample_tick_i(sample_tick),
            .clear_i(clr[gp]),
            .vrms_i(vrms_in[gp]),
            .irms_i(irms_in[gp]),
            .current_gain_i(current_gain_q[gp]),
            .voltage_rms_gain_i(voltage_rms_gain_q[gp]),
            .apparent_power_gain_i(apparent_power_gain_q[gp]),
            .divider_i(divider_q),
            .word_o(word[gp]),
            .acc_o(acc[gp])
         );
      end
   endgenerate

   // ----------------------------------------
   // total apparent power and pulse output
   // ----------------------------------------
   wire [25:0] term_a = total_phase_include[0] ? {2'h0, word[0]} : 26'h0; // R10
   wire [25:0] term_b = total_phase_include[1] ? {2'h0, word[1]} : 26'h0; // R10
   wire [25:0] term_c = total_phase_include[2] ? {2'h0, word[2]} : 26'h0; // R10
   wire [25:0] apparent_total = term_a + term_b + term_c;

   aea_pulse_dfc u_dfc (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .sample_tick_i(sample_tick),
      .apparent_sel_i(apparent_pulse_select),
      .apparent_total_i(apparent_total),
      .reactive_total_i(reactive_total_i),
      .numerator_i(pulse_num_q),
      .denominator_i(pulse_den_q),
      .pulse_o(reactive_pulse_out_o)
   );

   // ----------------------------------------
   // read path
   // ----------------------------------------
   wire [15:0] energy_view [3];
   assign energy_view[0] = line_cycle_apparent_en ? snap_q[0] : live_reg[0];
   assign energy_view[1] = line_cycle_apparent_en ? snap_q[1] : live_reg[1];
   assign energy_view[2] = line_cycle_apparent_en ? snap_q[2] : live_reg[2];

   wire [15:0] status_word = {14'h0, period_end_q, (lc_state_q == AEA_LC_RUN)};
   wire [15:0] rd_mux =
      (addr_i == `AEA_OFF_ENERGY_A) ? energy_view[0] :
      (addr_i == `AEA_OFF_ENERGY_B) ? energy_view[1] :
      (addr_i == `AEA_OFF_ENERGY_C) ? energy_view[2] :
      (addr_i == `AEA_OFF_COMPUTATION_MODE_REG) ? {11'h0, computation_mode_reg_q} :
      (addr_i == `AEA_OFF_WAVEMODE) ? {8'h0, wavemode_q} :
      (addr_i == `AEA_OFF_LINE_CYCLE_MODE_REG) ? {9'h0, line_cycle_mode_reg_q} :
      (addr_i == `AEA_OFF_DIVIDER) ? {8'h0, divider_q} :
      (addr_i == `AEA_OFF_VAGAIN0) ? {4'h0, apparent_power_gain_q[0]} :
      (addr_i == `AEA_OFF_VAGAIN0 + 8'h01) ? {4'h0, apparent_power_gain_q[1]} :
      (addr_i == `AEA_OFF_VAGAIN0 + 8'h02) ? {4'h0, apparent_power_gain_q[2]} :
      (addr_i == `AEA_OFF_IGAIN0) ? {4'h0, current_gain_q[0]} :
      (addr_i == `AEA_OFF_IGAIN0 + 8'h01) ? {4'h0, current_gain_q[1]} :
      (addr_i == `AEA_OFF_IGAIN0 + 8'h02) ? {4'h0, current_gain_q[2]} :
      (addr_i == `AEA_OFF_VRMSGAIN0) ? {4'h0, voltage_rms_gain_q[0]} :
      (addr_i == `AEA_OFF_VRMSGAIN0 + 8'h01) ? {4'h0, voltage_rms_gain_q[1]} :
      (addr_i == `AEA_OFF_VRMSGAIN0 + 8'h02) ? {4'h0, voltage_rms_gain_q[2]} :
      (addr_i == `AEA_OFF_PULSE_NUM) ? {4'h0, pulse_num_q} :
      (addr_i == `AEA_OFF_PULSE_DEN) ? {4'h0, pulse_den_q} :
      (addr_i == `AEA_OFF_ZC_COUNT) ? zc_count_q :
      (addr_i == `AEA_OFF_STATUS) ? status_word : 16'h0000;

   logic [15:0] rd_data_q;
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= rd_i ? rd_mux : 16'h0000;
      end
   end

   assign rd_data_o = rd_data_q;
   assign line_cycle_active_o = lc_active_q;
   assign line_cycle_reactive_o = lc_reactive_q;
   assign period_end_o = period_end_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_tick_period;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      sample_tick |=> !sample_tick [*3] ##1 sample_tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("sample tick not every four clocks"); // R01

   property p_reg_upper;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rd_energy[0] && !line_cycle_apparent_en) |=> (rd_data_o == $past(acc[0][40:25]));
   endproperty
   a_reg_upper: assert property (p_reg_upper) else $error("energy read not upper accumulator bits"); // R18

   property p_read_clear;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rd_energy[1] && read_with_clear && !line_cycle_apparent_en) |=>
         (acc[1] == 41'h0 || acc[1] == {17'h0, $past(word[1])});
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read with clear left energy"); // R20

   property p_lc_snap;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      lc_done |=> (snap_q[0] == $past(acc[0][40:25])) && period_end_o;
   endproperty
   a_lc_snap: assert property (p_lc_snap) else $error("period total not latched"); // R13

   property p_lc_restart;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      lc_done |=> (acc[0] <= {17'h0, $past(word[0])});
   endproperty
   a_lc_restart: assert property (p_lc_restart) else $error("period did not restart from zero"); // R21

   property p_mode_avg;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (phase_input_select == AEA_SEL_AVG_B) |-> (vrms_in[1] == v_avg_ac);
   endproperty
   a_mode_avg: assert property (p_mode_avg) else $error("phase b not using a/c average"); // R06

   property p_total_mask;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (total_phase_include == 3'h1) |-> (apparent_total == {2'h0, word[0]});
   endproperty
   a_total_mask: assert property (p_total_mask) else $error("excluded phase in total"); // R10

   c_lc_period: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) lc_done);
   c_read_clear: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
      rd_energy[0] && read_with_clear);
   c_pulse: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
      apparent_pulse_select && reactive_pulse_out_o);

endmodule : aea_top

// *** aea_host.sv ***
// Purpose: host model on the register port
// Assumes: one-cycle strobes, data in next cycle
// Notes: gains stay at reset value
`timescale 1ns/10ps
module aea_host (
   // bus
   input wire logic clk_i,
   input wire logic [15:0] rd_data_i,
   output logic [7:0] addr_o,
   output logic [15:0] wr_data_o,
   output logic wr_o,
   output logic rd_o
);
   initial begin
      addr_o = 8'h00;
      wr_data_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      addr_o <= a;
      wr_data_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rd_data_i;
      @(posedge clk_i);
   endtask : rd
endmodule : aea_host

// *** aea_top_bench.sv ***
// Purpose: self-checking bench for aea_top
// Assumes: 0x8000 x 0x8000 load on phase A, and on phase B only in averaging mode
// Notes: expectations from word size and tick count
`timescale 1ns/10ps
module aea_top_bench;
   // ----------------------------------------
   // wiring
   // ----------------------------------------
   localparam longint WORD = ((64'h8000 * 64'h8000) >> 12) * 4098 / 4096;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic wr;
   logic rd;
   logic [15:0] va = 16'h8000;
   logic [15:0] vb = 16'h0000;
   logic [15:0] ia = 16'h8000;
   logic zc = 1'b0;
   logic [25:0] vart = 26'h0000000;
   logic pulse;
   logic lca;
   logic lcr;
   logic pend;
   int fail_count = 0;
   int n_compared = 0;
   int pc = 0;
   always #25 clk = ~clk;
   always @(posedge clk) if (pulse === 1'b1) pc++;
   aea_top aea_top_inst (.ref_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wr_data_i(wdata),
      .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .vrms_a_i(va), .vrms_b_i(vb), .vrms_c_i(va),
      .irms_a_i(ia), .irms_b_i(ia), .irms_c_i(16'h0000), .zero_cross_i(zc),
      .reactive_total_i(vart), .reactive_pulse_out_o(pulse),
      .line_cycle_active_o(lca), .line_cycle_reactive_o(lcr), .period_end_o(pend));
   aea_host aea_host_inst (.clk_i(clk), .rd_data_i(rdata), .addr_o(addr), .wr_data_o(wdata),
      .wr_o(wr), .rd_o(rd));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   function automatic logic [15:0] expe(input int n, input int dv);
      return 16'((longint'(n) * (WORD / dv)) >> 25);
   endfunction : expe
   task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      aea_host_inst.rd(a, d);
      chk(n, e, d);
   endtask : rchk
   task automatic ticks(input int n);
      repeat (4 * n) @(posedge clk);
   endtask : ticks
   task automatic w(input logic [7:0] a, input logic [15:0] d);
      aea_host_inst.wr(a, d);
   endtask : w
   task automatic t_accum;
      rchk("den", 8'h11, 16'h003F);
      rchk("unmapped", 8'hFF, 16'h0000);
      ticks(1300);
      rchk("energy_a", 8'h00, expe(1300, 1));
      rchk("energy_b", 8'h01, 16'h0000);
      w(8'h05, 16'h0040);
      rchk("a_clr", 8'h00, expe(1300, 1));
      rchk("a_zero", 8'h00, 16'h0000);
      w(8'h06, 16'h0002);
      ticks(1300);
      rchk("a_div", 8'h00, expe(1300, 2));
      w(8'h06, 16'h0000);
      w(8'h03, 16'h001D);
      ticks(1300);
      rchk("b_avg", 8'h01, expe(1300, 1));
      $display("accum test done");
   endtask : t_accum
   task automatic zcross;
      zc <= 1'b1;
      @(posedge clk);
      zc <= 1'b0;
      // period marker stands only until the next rising edge
      @(negedge clk);
   endtask : zcross
   task automatic t_lc;
      w(8'h12, 16'h0002);
      w(8'h05, 16'h0007);
      @(negedge clk);
      chk("lc_bits", 16'h0003, {14'h0000, lcr, lca});
      repeat (2) begin
         ticks(650);
         zcross;
         ticks(650);
         zcross;
         chk("period_end", 16'h0001, {15'h0000, pend});
         @(posedge clk);
         rchk("lc_a", 8'h00, expe(1300, 1));
      end
      $display("line cycle test done");
   endtask : t_lc
   task automatic pwin(input int lo, input int hi);
      int p0;
      ticks(8);
      p0 = pc;
      ticks(400);
      chk("pulses", 16'h0001, 16'(((pc - p0) >= lo) && ((pc - p0) <= hi)));
   endtask : pwin
   task automatic t_pulse;
      w(8'h05, 16'h0000);
      w(8'h03, 16'h0004);
      w(8'h04, 16'h0080);
      w(8'h10, 16'h0001);
      w(8'h11, 16'h0001);
      pwin(99, 101);
      w(8'h11, 16'h0004);
      pwin(24, 26);
      w(8'h03, 16'h0000);
      pwin(0, 0);
      w(8'h03, 16'h0004);
      vart <= 26'h0100000;
      pwin(24, 26);
      w(8'h04, 16'h0000);
      pwin(99, 101);
      $display("pulse test done");
   endtask : t_pulse
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_accum;
      t_lc;
      t_pulse;
      wrap_up;
   end
   // hang guard, about 1.75 times the expected run
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      wrap_up;
   end
endmodule : aea_top_bench
